// *** verilog/self_program_flash_mapping.sv ***
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module self_program_flash_mapping
	import self_program_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Status inputs and straps
	input wire logic eeprom_write_busy_bit,
	input wire logic rc_osc_pin,
	input wire logic boot_size_fuse_hi,
	input wire logic boot_size_fuse_lo,
	// CPU read path
	input wire logic [15:0] fetch_addr,
	input wire logic [15:0] flash_rdata,
	output logic [15:0] fetch_rdata,
	output logic fetch_blocked,
	// Flash array side
	output logic flash_erase_pulse,
	output logic flash_program_pulse,
	output logic flash_lock_pulse,
	output logic [PAGE_BITS-1:0] page_number_field,
	output logic [7:0] lock_value,
	input wire logic [WORD_BITS-1:0] buf_rd_index,
	output logic [15:0] buf_rd_data,
	output logic op_busy,
	output logic [15:0] boot_start_addr,
	output logic irq
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	seq_state_type state, next_state; // Sequencer state
	logic [4:0] ctrl, next_ctrl; // Latched command bits
	logic [2:0] window, next_window; // Store window countdown
	logic [12:0] busy_cnt, next_busy_cnt; // RC ticks left
	logic rww_busy, next_rww_busy; // rww_busy_flag
	logic op_rww, next_op_rww; // Running operation targets lower area
	logic [15:0] pointer, next_pointer; // Z pointer
	logic ext_page, next_ext_page; // extended_page_pointer_reg bit 0
	logic [15:0] data_word, next_data_word; // r1:r0 image
	logic [1:0] irq_status, next_irq_status; // Sticky events
	logic [1:0] irq_enable, next_irq_enable; // Event mask
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [PAGE_BITS-1:0] next_page;
	logic [7:0] next_lock_value;
	logic next_erase_pulse, next_program_pulse, next_lock_pulse;
	logic [15:0] next_fetch_rdata;
	logic next_fetch_blocked;
	logic [15:0] next_boot_start;
	logic next_irq;
	logic buf_we; // Buffer load strobe
	logic ev_done, ev_refused; // One-cycle events
	logic rc_level, rc_prev; // Synchronised RC clock and history
	logic rc_tick; // One pclk pulse per RC period
	logic [1:0] fuse_level; // Synchronised fuse code
	logic access; // APB access phase completes
	logic wr_ctrl, wr_store; // Decoded writes
	logic [16:0] ext_pointer; // Full byte pointer
	logic [15:0] target_word; // Word address of the command
	logic mapped; // Address decodes to a register

	// ----------------------------------------
	// Input synchronisers and buffer
	// ----------------------------------------
	// RC oscillator is asynchronous to pclk
	pin_sync #(.WIDTH(1)) rc_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(rc_osc_pin),
		.level(rc_level)
	);

	// Fuses are straps but still cross in
	pin_sync #(.WIDTH(2)) fuse_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin({boot_size_fuse_hi, boot_size_fuse_lo}),
		.level(fuse_level)
	);

	// Word address is the pointer with bit 0 dropped
	page_buffer buffer (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(buf_we),
		.wr_index(ext_pointer[WORD_BITS:1]),
		.wr_data(data_word),
		.rd_index(buf_rd_index),
		.rd_data(buf_rd_data)
	);

	// ----------------------------------------
	// Address mapping
	// ----------------------------------------
	// Bit 16 comes from the extended register, bit 0 is unused by stores
	always_comb begin
		ext_pointer = {ext_page, pointer};
		target_word = ext_pointer[16:1];
		next_page = ext_pointer[16:WORD_BITS+1];
		rc_tick = rc_level & ~rc_prev;
		access = psel & penable & pready;
		wr_ctrl = access & pwrite & (paddr == OFS_CONTROL);
		wr_store = access & pwrite & (paddr == OFS_STORE);
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Command arm, store window, timed operation
	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_window = window;
		next_busy_cnt = busy_cnt;
		next_rww_busy = rww_busy;
		next_op_rww = op_rww;
		next_lock_value = lock_value;
		next_erase_pulse = 1'b0;
		next_program_pulse = 1'b0;
		next_lock_pulse = 1'b0;
		buf_we = 1'b0;
		ev_done = 1'b0;
		ev_refused = 1'b0;
		unique case (state)
			st_idle: begin
				// Control writes while an EEPROM write runs are dropped
				if (wr_ctrl && eeprom_write_busy_bit) begin
					ev_refused = 1'b1;
				end else if (wr_ctrl && pwdata[SPM_EN_POS]) begin
					next_ctrl = pwdata[4:0];
					next_window = STORE_WINDOW;
					next_state = st_armed;
				end
			end
			st_armed: begin
				if (wr_store) begin
					if (ctrl[ERASE_POS] || ctrl[WRITE_POS]) begin
						next_erase_pulse = ctrl[ERASE_POS];
						next_program_pulse = ~ctrl[ERASE_POS];
						next_busy_cnt = PROG_TICKS;
						next_op_rww = (target_word < RWW_LIMIT);
						next_rww_busy = rww_busy | (target_word < RWW_LIMIT);
						next_state = st_busy;
					end else if (ctrl[LOCK_POS]) begin
						// Lock writes block no reads themselves; rww_busy keeps its value
						next_lock_pulse = 1'b1;
						next_lock_value = data_word[7:0];
						next_busy_cnt = PROG_TICKS;
						next_op_rww = 1'b0;
						next_state = st_busy;
					end else if (ctrl[REEN_POS]) begin
						next_rww_busy = 1'b0;
						next_ctrl = CONTROL_RESET;
						next_state = st_idle;
					end else begin
						buf_we = 1'b1;
						next_ctrl = CONTROL_RESET;
						next_state = st_idle;
					end
				end else if (window == 3'h1) begin
					// Store came too late: command lapses
					next_ctrl = CONTROL_RESET;
					ev_refused = 1'b1;
					next_state = st_idle;
				end else begin
					next_window = window - 3'h1;
				end
			end
			st_busy: begin
				// Count RC periods, not pclk cycles
				if (rc_tick) begin
					if (busy_cnt == 13'h0001) begin
						next_ctrl = CONTROL_RESET;
						next_op_rww = 1'b0;
						ev_done = 1'b1;
						next_state = st_idle;
					end else begin
						next_busy_cnt = busy_cnt - 13'h0001;
					end
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
			ctrl <= CONTROL_RESET;
			window <= 3'h0;
			busy_cnt <= 13'h0000;
			rww_busy <= 1'b0;
			op_rww <= 1'b0;
			lock_value <= 8'hFF;
			flash_erase_pulse <= 1'b0;
			flash_program_pulse <= 1'b0;
			flash_lock_pulse <= 1'b0;
			page_number_field <= '0;
			op_busy <= 1'b0;
			rc_prev <= 1'b0;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			window <= next_window;
			busy_cnt <= next_busy_cnt;
			rww_busy <= next_rww_busy;
			op_rww <= next_op_rww;
			lock_value <= next_lock_value;
			flash_erase_pulse <= next_erase_pulse;
			flash_program_pulse <= next_program_pulse;
			flash_lock_pulse <= next_lock_pulse;
			if (next_erase_pulse || next_program_pulse) begin
				page_number_field <= next_page;
			end
			op_busy <= (next_state == st_busy);
			rc_prev <= rc_level;
		end
	end

	// ----------------------------------------
	// Read blocking and boot area
	// ----------------------------------------
	// Lower area unreadable while a lower-area erase or write runs or until re-enabled
	always_comb begin
		next_fetch_blocked = (rww_busy | op_rww) & (fetch_addr < RWW_LIMIT);
		next_fetch_rdata = next_fetch_blocked ? 16'h0000 : flash_rdata;
		// Boot area sits at the top; size doubles per cleared fuse step
		next_boot_start = ~((BOOT_MIN_WORDS << (2'h3 - fuse_level)) - 16'h0001);
	end

	// Read path and fuse capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_rdata <= 16'h0000;
			fetch_blocked <= 1'b0;
			boot_start_addr <= 16'hF000;
		end else begin
			fetch_rdata <= next_fetch_rdata;
			fetch_blocked <= next_fetch_blocked;
			// Follows the synchronised straps; a strap change shows five edges later
			boot_start_addr <= next_boot_start;
		end
	end

	// ----------------------------------------
	// APB register file
	// ----------------------------------------
	// Zero-wait slave: answer in the cycle after setup
	always_comb begin
		next_pointer = pointer;
		next_ext_page = ext_page;
		next_data_word = data_word;
		next_irq_enable = irq_enable;
		next_irq_status = irq_status;
		mapped = 1'b1;
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			OFS_CONTROL: next_prdata = {25'h000_0000, rww_busy, 1'b0, ctrl};
			OFS_POINTER: next_prdata = {16'h0000, pointer};
			OFS_EXT_PAGE: next_prdata = {31'h0000_0000, ext_page};
			OFS_DATA: next_prdata = {16'h0000, data_word};
			OFS_STORE: next_prdata = 32'h0000_0000;
			OFS_IRQ_STATUS: next_prdata = {30'h0000_0000, irq_status};
			OFS_IRQ_CLEAR: next_prdata = 32'h0000_0000;
			OFS_IRQ_ENABLE: next_prdata = {30'h0000_0000, irq_enable};
			OFS_BOOT_INFO: next_prdata = {boot_start_addr, 14'h0000, fuse_level};
			default: mapped = 1'b0;
		endcase
		next_pready = psel & ~penable;
		next_pslverr = psel & ~penable & ~mapped;
		if (access && pwrite) begin
			if (paddr == OFS_POINTER) begin
				next_pointer = pwdata[15:0];
			end
			if (paddr == OFS_EXT_PAGE) begin
				next_ext_page = pwdata[0];
			end
			if (paddr == OFS_DATA) begin
				next_data_word = pwdata[15:0];
			end
			if (paddr == OFS_IRQ_ENABLE) begin
				next_irq_enable = pwdata[1:0];
			end
			if (paddr == OFS_IRQ_CLEAR) begin
				next_irq_status = irq_status & ~pwdata[1:0];
			end
		end
		// A new event wins over a clear in the same cycle
		next_irq_status[IRQ_DONE_POS] = next_irq_status[IRQ_DONE_POS] | ev_done;
		next_irq_status[IRQ_REFUSED_POS] = next_irq_status[IRQ_REFUSED_POS] | ev_refused;
		next_irq = |(next_irq_status & next_irq_enable);
	end

	// Register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pointer <= POINTER_RESET;
			ext_page <= 1'b0;
			data_word <= 16'h0000;
			irq_enable <= IRQ_RESET;
			irq_status <= IRQ_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			pointer <= next_pointer;
			ext_page <= next_ext_page;
			data_word <= next_data_word;
			irq_enable <= next_irq_enable;
			irq_status <= next_irq_status;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq <= next_irq;
		end
	end

endmodule // self_program_flash_mapping

// *** verilog/self_program_pkg.sv ***
package self_program_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00; // Command and busy flag
	localparam logic [7:0] OFS_POINTER = 8'h04; // Byte pointer bits 15:0
	localparam logic [7:0] OFS_EXT_PAGE = 8'h08; // Pointer bit 16
	localparam logic [7:0] OFS_DATA = 8'h0C; // Word for buffer or lock byte
	localparam logic [7:0] OFS_STORE = 8'h10; // Write executes the store
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14; // Sticky events, read only
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18; // Write one to clear
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C; // Event mask
	localparam logic [7:0] OFS_BOOT_INFO = 8'h20; // Fuse code and boot start

	// ----------------------------------------
	// Register field positions
	// ----------------------------------------
	localparam int SPM_EN_POS = 0; // self_program_enable_bit
	localparam int ERASE_POS = 1; // page_erase_cmd_bit
	localparam int WRITE_POS = 2; // page_write_cmd_bit
	localparam int LOCK_POS = 3; // lock bit write command
	localparam int REEN_POS = 4; // rww_reenable_cmd_bit
	localparam int RWW_BUSY_POS = 6; // rww_busy_flag
	localparam int IRQ_DONE_POS = 0; // Timed operation finished
	localparam int IRQ_REFUSED_POS = 1; // Command dropped
	localparam int BOOT_START_POS = 16; // Boot start in BOOT_INFO

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [4:0] CONTROL_RESET = 5'h00;
	localparam logic [15:0] POINTER_RESET = 16'h0000;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// ----------------------------------------
	// Flash geometry
	// ----------------------------------------
	localparam int PAGE_WORDS = 128; // Words per page
	localparam int WORD_BITS = 7; // Word-in-page field width
	localparam int PAGE_BITS = 9; // Page number field width
	localparam logic [15:0] RWW_LIMIT = 16'hF000; // First word above lower area
	localparam logic [15:0] BOOT_MIN_WORDS = 16'h0200; // Size for fuse code 11

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int RC_KHZ = 1000; // Nominal RC oscillator rate
	localparam int PROG_MIN_US = 3700; // Shortest programming time
	localparam int PROG_MAX_US = 4500; // Longest programming time
	localparam int PROG_TICKS_INT = (PROG_MIN_US * RC_KHZ + 999) / 1000;
	localparam logic [12:0] PROG_TICKS = PROG_TICKS_INT[12:0]; // RC periods per operation
	localparam logic [2:0] STORE_WINDOW = 3'h4; // pclk cycles to issue the store

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_armed = 3'b010,
		st_busy = 3'b100
	} seq_state_type;

endpackage

// *** verilog/pin_sync.sv ***
`timescale 1ns/100ps
// Three-stage synchroniser; level moves when stages two and three agree
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);

	logic [WIDTH-1:0] stage1; // Read only by stage2
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	// ----------------------------------------
	// Filter
	// ----------------------------------------
	// A bit changes only once two settled stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
		end
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level <= '0;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			level <= next_level;
		end
	end

endmodule // pin_sync

// *** verilog/page_buffer.sv ***
`timescale 1ns/100ps
// Temporary page buffer, one flip-flop word per page word
module page_buffer
	import self_program_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [WORD_BITS-1:0] wr_index,
	input wire logic [15:0] wr_data,
	input wire logic [WORD_BITS-1:0] rd_index,
	output logic [15:0] rd_data
);

	logic [15:0] mem [PAGE_WORDS]; // Buffer storage
	logic [15:0] next_rd_data;

	// Registered read port
	always_comb begin
		next_rd_data = mem[rd_index];
	end

	// Storage and read register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				mem[i] <= 16'hFFFF;
			end
			rd_data <= 16'h0000;
		end else begin
			if (wr_en) begin
				mem[wr_index] <= wr_data;
			end
			rd_data <= next_rd_data;
		end
	end

endmodule // page_buffer

// *** verif/flash_seq_assertions.sv ***
`timescale 1ns/100ps
// --------
// Port checks of the flash sequencer
// --------
module flash_seq_assertions
	import self_program_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic eeprom_write_busy_bit,
	input wire logic boot_size_fuse_hi,
	input wire logic boot_size_fuse_lo,
	input wire logic [15:0] fetch_addr,
	input wire logic [15:0] flash_rdata,
	input wire logic [15:0] fetch_rdata,
	input wire logic fetch_blocked,
	input wire logic flash_erase_pulse,
	input wire logic flash_program_pulse,
	input wire logic flash_lock_pulse,
	input wire logic op_busy,
	input wire logic [15:0] boot_start_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Any timed launch this cycle
	wire logic any_pulse = flash_erase_pulse | flash_program_pulse | flash_lock_pulse;
	wire logic [1:0] fuse = {boot_size_fuse_hi, boot_size_fuse_lo};
	// Fuses quiet long enough for the synchroniser
	sequence fuse_settled;
		$stable(fuse)[*8];
	endsequence
	// A launch must not end within a handful of cycles
	sequence busy_run;
		op_busy ##1 op_busy[*8];
	endsequence
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_blocked_reads_zero: assert property (fetch_blocked |-> fetch_rdata == 16'h0000)
		else $error("blocked fetch returned data");
	a_open_reads_pass: assert property ($past(presetn) && !fetch_blocked |-> fetch_rdata == $past(flash_rdata))
		else $error("open fetch lost data");
	a_block_low_only: assert property (fetch_blocked |-> $past(fetch_addr) < RWW_LIMIT)
		else $error("upper area blocked");
	a_launch_runs: assert property (any_pulse |-> busy_run)
		else $error("operation too short");
	a_busy_from_launch: assert property ($rose(op_busy) |-> any_pulse)
		else $error("busy without launch");
	a_no_launch_busy: assert property ($past(op_busy) && op_busy |-> !any_pulse)
		else $error("launch while busy");
	a_enable_while_busy: assert property (pready && !pwrite && paddr == OFS_CONTROL && $past(op_busy)
		|-> prdata[SPM_EN_POS])
		else $error("enable bit low while busy");
	a_eeprom_blocks: assert property (eeprom_write_busy_bit[*8] |-> !any_pulse)
		else $error("launch during eeprom write");
	a_boot_start: assert property (fuse_settled |-> boot_start_addr == (fuse == 2'b11 ? 16'hFE00 :
		fuse == 2'b10 ? 16'hFC00 : fuse == 2'b01 ? 16'hF800 : 16'hF000))
		else $error("boot start wrong");
endmodule // flash_seq_assertions

// *** verif/boot_cpu_model.sv ***
`timescale 1ns/100ps
// --------
// Boot loader CPU: APB master and store sequence
// --------
module boot_cpu_model
	import self_program_pkg::*;
(
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic eeprom_write_busy_bit
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// One transfer; an idle edge follows so psel is never set twice at once
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Timed pair, guarded as the boot loader does it
	task automatic do_spm(input logic [7:0] cmd);
		logic [31:0] r;
		logic e;
		r = 32'h0000_0001;
		while (r[SPM_EN_POS] !== 1'b0) xfer(1'b0, OFS_CONTROL, 32'h0000_0000, r, e);
		while (eeprom_write_busy_bit !== 1'b0) @(posedge pclk);
		// No interrupt may split the pair below
		xfer(1'b1, OFS_CONTROL, {24'h00_0000, cmd}, r, e);
		xfer(1'b1, OFS_STORE, 32'h0000_0000, r, e);
	endtask
endmodule // boot_cpu_model

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench
	import self_program_pkg::*;
;
	// --------
	// Signals
	// --------
	logic pclk = 1'b0;
	logic rc_osc_pin = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, eeprom_write_busy_bit;
	logic boot_size_fuse_hi, boot_size_fuse_lo, fetch_blocked, irq, op_busy;
	logic flash_erase_pulse, flash_program_pulse, flash_lock_pulse;
	logic [7:0] paddr, lock_value;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] fetch_addr, flash_rdata, fetch_rdata, buf_rd_data, boot_start_addr;
	logic [PAGE_BITS-1:0] page_number_field, page_seen;
	logic [WORD_BITS-1:0] buf_rd_index;
	logic rerr;
	int bad_count = 0;
	int n_compared = 0;
	int ticks;
	int cnt [3];
	// RC runs fast to keep the run short; each level spans two rising pclk edges
	// so the synchroniser filter keeps every period, and it toggles on falling edges
	always #20 pclk = ~pclk;
	always #80 rc_osc_pin = ~rc_osc_pin;
	// Array contents as a simple function of the address
	assign flash_rdata = fetch_addr ^ 16'hA5A5;
	self_program_flash_mapping u_dut (.*);
	boot_cpu_model u_cpu (.*);
	// Launch counts and the page carried by a launch
	always @(posedge pclk) begin
		if (flash_erase_pulse === 1'b1) cnt[0]++;
		if (flash_program_pulse === 1'b1) cnt[1]++;
		if (flash_lock_pulse === 1'b1) cnt[2]++;
		if ((flash_erase_pulse | flash_program_pulse) === 1'b1) page_seen = page_number_field;
	end
	always @(posedge rc_osc_pin) if (op_busy === 1'b1) ticks++;
	// --------
	// Helpers
	// --------
	task automatic chk(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_cpu.xfer(1'b1, a, d, rdat, rerr);
	endtask
	task automatic rd(input logic [7:0] a);
		u_cpu.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
	endtask
	// Fetch one word; a blocked one must come back blank
	task automatic look(input logic [15:0] a, input logic blk);
		fetch_addr <= a;
		repeat (2) @(posedge pclk);
		chk(fetch_blocked === blk && fetch_rdata === (blk ? 16'h0000 : a ^ 16'hA5A5), "fetch");
	endtask
	task automatic start_op(input logic [7:0] cmd);
		ticks = 0;
		cnt = '{0, 0, 0};
		u_cpu.do_spm(cmd);
		repeat (3) @(posedge pclk);
		chk(op_busy === 1'b1, "op start");
	endtask
	// Length is judged in RC periods, never in pclk cycles
	task automatic finish_op(input int kind);
		rd(OFS_CONTROL);
		chk(rdat[SPM_EN_POS] === 1'b1, "enable held");
		while (op_busy === 1'b1) @(posedge pclk);
		chk(ticks >= PROG_MIN_US * RC_KHZ / 1000 - 1 && ticks <= PROG_MAX_US * RC_KHZ / 1000, "length");
		chk(cnt[kind] === 1 && cnt[0] + cnt[1] + cnt[2] === 1, "one launch");
		rd(OFS_CONTROL);
		chk(rdat[SPM_EN_POS] === 1'b0, "enable cleared");
		rd(OFS_IRQ_STATUS);
		chk(rdat[IRQ_DONE_POS] === 1'b1 && irq === 1'b1, "done event");
		wr(OFS_IRQ_CLEAR, 32'h0000_0001);
		rd(OFS_IRQ_STATUS);
		chk(rdat[IRQ_DONE_POS] === 1'b0 && irq === 1'b0, "done cleared");
	endtask
	// --------
	// Scenarios
	// --------
	task automatic t_map();
		logic [15:0] exp;
		rd(OFS_CONTROL);
		chk(rdat === 32'h0000_0000 && lock_value === 8'hFF, "reset values");
		rd(8'h40);
		chk(rerr === 1'b1 && rdat === 32'h0000_0000, "unmapped");
		wr(OFS_IRQ_STATUS, 32'h0000_0003);
		rd(OFS_IRQ_STATUS);
		chk(rdat === 32'h0000_0000, "status read only");
		wr(OFS_IRQ_ENABLE, 32'h0000_0001);
		for (int c = 0; c < 4; c++) begin
			{boot_size_fuse_hi, boot_size_fuse_lo} <= 2'(c);
			repeat (8) @(posedge pclk);
			exp = 16'(32'h0001_0000 - (32'h0000_0200 << (3 - c)));
			chk(boot_start_addr === exp, "boot start");
			rd(OFS_BOOT_INFO);
			chk(rdat === {exp, 14'h0000, 2'(c)}, "boot info");
		end
	endtask
	// Stray byte-select bit and stray page bits must not move the word
	task automatic t_buffer();
		logic [15:0] ptr [2] = '{16'h0001, 16'h35FE};
		logic [15:0] dat [2] = '{16'h1234, 16'hABCD};
		for (int i = 0; i < 2; i++) begin
			wr(OFS_POINTER, {16'h0000, ptr[i]});
			wr(OFS_DATA, {16'h0000, dat[i]});
			u_cpu.do_spm(8'h01);
			buf_rd_index <= ptr[i][7:1];
			repeat (3) @(posedge pclk);
			chk(buf_rd_data === dat[i] && op_busy === 1'b0, "buffer word");
		end
	endtask
	task automatic t_erase();
		wr(OFS_EXT_PAGE, 32'h0000_0001);
		wr(OFS_POINTER, 32'h0000_6000);
		start_op(8'h03);
		chk(page_seen === 9'h160, "erase page");
		look(16'hB000, 1'b1);
		look(16'hF000, 1'b0);
		rd(OFS_CONTROL);
		chk(rdat[RWW_BUSY_POS] === 1'b1, "rww busy");
		finish_op(0);
		look(16'hB000, 1'b1);
		u_cpu.do_spm(8'h11);
		rd(OFS_CONTROL);
		chk(rdat[RWW_BUSY_POS] === 1'b0, "rww ready");
		look(16'hB000, 1'b0);
	endtask
	task automatic t_write();
		wr(OFS_EXT_PAGE, 32'h0000_0000);
		wr(OFS_POINTER, 32'h0000_2100);
		start_op(8'h05);
		chk(page_seen === 9'h021, "write page");
		look(16'hEFFF, 1'b1);
		finish_op(1);
		u_cpu.do_spm(8'h11);
		look(16'h1080, 1'b0);
	endtask
	task automatic t_lock();
		wr(OFS_DATA, 32'h0000_00C3);
		start_op(8'h09);
		chk(lock_value === 8'hC3, "lock value");
		look(16'h0000, 1'b0);
		finish_op(2);
	endtask
	// Control write during an eeprom write is made on purpose here
	task automatic t_refuse();
		eeprom_write_busy_bit <= 1'b1;
		repeat (9) @(posedge pclk);
		wr(OFS_CONTROL, 32'h0000_0003);
		rd(OFS_CONTROL);
		chk(rdat[4:0] === 5'h00, "armed in eeprom write");
		eeprom_write_busy_bit <= 1'b0;
		wr(OFS_CONTROL, 32'h0000_0001);
		repeat (6) @(posedge pclk);
		rd(OFS_CONTROL);
		chk(rdat[SPM_EN_POS] === 1'b0, "window left open");
		rd(OFS_IRQ_STATUS);
		chk(rdat[IRQ_REFUSED_POS] === 1'b1 && irq === 1'b0, "refused masked");
		wr(OFS_IRQ_ENABLE, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk(irq === 1'b1, "refused raised");
		wr(OFS_IRQ_CLEAR, 32'h0000_0002);
		rd(OFS_IRQ_STATUS);
		chk(rdat[1:0] === 2'b00 && irq === 1'b0, "refused cleared");
	endtask
	task automatic report_and_stop();
		if (bad_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		presetn = 1'b0;
		eeprom_write_busy_bit = 1'b0;
		boot_size_fuse_hi = 1'b0;
		boot_size_fuse_lo = 1'b0;
		fetch_addr = 16'h0000;
		buf_rd_index = 7'h00;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_map();
		t_buffer();
		t_erase();
		t_write();
		t_lock();
		t_refuse();
		report_and_stop();
	end
	// Three timed operations need about 45000 cycles
	initial begin
		#(60000 * 40);
		bad_count++;
		report_and_stop();
	end
endmodule // testbench
bind self_program_flash_mapping flash_seq_assertions u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .eeprom_write_busy_bit(eeprom_write_busy_bit),
	.boot_size_fuse_hi(boot_size_fuse_hi), .boot_size_fuse_lo(boot_size_fuse_lo),
	.fetch_addr(fetch_addr), .flash_rdata(flash_rdata), .fetch_rdata(fetch_rdata), .fetch_blocked(fetch_blocked),
	.flash_erase_pulse(flash_erase_pulse), .flash_program_pulse(flash_program_pulse),
	.flash_lock_pulse(flash_lock_pulse), .op_busy(op_busy), .boot_start_addr(boot_start_addr)
);
